// >>> hdl/sfp_pin_if.sv
`timescale 1ns/1ps
module sfp_pin_if (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rst,
	// link pins
	input  wire logic        selectN,
	input  wire logic        sclk,
	input  wire logic [3:0]  laneIn,
	output logic      [3:0]  laneOut_q,
	output logic      [3:0]  laneOe_q,
	input  wire logic        dedResetN,
	// configuration
	input  wire logic        dedicatedVariant,
	input  wire logic        pinRoleSelect,
	input  wire logic        dedResetDisable,
	input  wire logic [1:0]  laneMode,
	// receive side toward the decoder
	output logic [7:0]       rxByte_q,
	output logic             rxValid_q,
	// transmit side from the decoder
	input  wire logic        txLoad,
	input  wire logic [7:0]  txByte,
	// status bits and their write port
	input  wire logic        stWrReq,
	input  wire logic [5:0]  stWrData,
	output logic [5:0]       statusBits_q,
	output logic             stWrRejected_q,
	// state indicators
	output logic             standby_q,
	output logic             pauseActive_q,
	output logic             hwResetActive_q
);
	// synchronised pins
	logic [sfp_pkg::PIN_COUNT-1:0] pinSync;
	logic                          selN;
	logic                          sclkS;
	logic [3:0]                    lanes;
	logic                          dedRstS;
	// edge history
	logic                          sclkPrev_q, sclkPrev_d;
	logic                          selPrev_q, selPrev_d;
	// sequencing and shift state
	sfp_pkg::sfp_state_t           state_q, state_d;
	logic [7:0]                    rxShift_q, rxShift_d;
	logic [3:0]                    rxCnt_q, rxCnt_d;
	logic [7:0]                    txShift_q, txShift_d;
	logic                          txActive_q, txActive_d;
	// next values of the outputs
	logic [3:0]                    laneOut_d, laneOe_d;
	logic [7:0]                    rxByte_d;
	logic                          rxValid_d;
	logic [5:0]                    statusBits_d;
	logic                          stWrRejected_d;
	// decoded conditions
	logic quadEnableBit, swd, holdRole, rstRole, hwRst, paused, rise, fall, quadOk;
	logic [3:0] step, cntSum;

	sfp_sync u_sync (
		.mclk     (mclk),
		.rst      (rst),
		.pinAsync ({dedResetN, laneIn, sclk, selectN}),
		.pinSync  (pinSync)
	);

	assign selN    = pinSync[sfp_pkg::PIN_SEL];
	assign sclkS   = pinSync[sfp_pkg::PIN_SCLK];
	assign lanes   = pinSync[sfp_pkg::PIN_LANE0 +: 4];
	assign dedRstS = pinSync[sfp_pkg::PIN_DRST];

	// pin roles and edge detection
	always_comb begin
		quadEnableBit = statusBits_q[sfp_pkg::STAT_QUAD_POS];
		swd           = statusBits_q[sfp_pkg::STAT_SWD_POS];
		holdRole = !quadEnableBit && (dedicatedVariant || !pinRoleSelect);
		rstRole  = !quadEnableBit && !dedicatedVariant && pinRoleSelect;
		// reset from lane 3 or dedicated pin
		hwRst = (rstRole && !lanes[3]) ||
			(dedicatedVariant && !dedResetDisable && !dedRstS);
		paused = holdRole && !lanes[3] && !selN;
		// edges found both ways, so idle level high or low both work
		rise = sclkS && !sclkPrev_q;
		fall = !sclkS && sclkPrev_q;
		// quad needs lanes 2 and 3 freed by quad enable
		quadOk = quadEnableBit && (laneMode == sfp_pkg::LANES_QUAD);
		if (quadOk) begin
			step = sfp_pkg::STEP_QUAD;
		end else if (laneMode == sfp_pkg::LANES_DUAL) begin
			step = sfp_pkg::STEP_DUAL;
		end else begin
			step = sfp_pkg::STEP_SINGLE;
		end
		cntSum = rxCnt_q + step;
	end

	// sequencing, shifting and lane drive
	always_comb begin
		sclkPrev_d     = sclkS;
		selPrev_d      = selN;
		state_d        = state_q;
		rxShift_d      = rxShift_q;
		rxCnt_d        = rxCnt_q;
		txShift_d      = txShift_q;
		txActive_d     = txActive_q;
		laneOut_d      = laneOut_q;
		laneOe_d       = 4'h0;
		rxByte_d       = rxByte_q;
		rxValid_d      = 1'b0;
		statusBits_d   = statusBits_q;
		stWrRejected_d = 1'b0;
		unique case (state_q)
			// wait for the first falling select
			sfp_pkg::ST_WAITFALL: begin
				if (selPrev_q && !selN) begin
					state_d = sfp_pkg::ST_SEL;
				end
			end
			// idle, armed for the next instruction
			sfp_pkg::ST_DESEL: begin
				if (!selN) begin
					state_d = sfp_pkg::ST_SEL;
				end
			end
			sfp_pkg::ST_SEL: begin
				if (selN) begin
					state_d = sfp_pkg::ST_DESEL;
				end
			end
		endcase
		// partial bytes and drive cleared on leaving select
		if (state_d != sfp_pkg::ST_SEL) begin
			rxCnt_d    = 4'h0;
			txActive_d = 1'b0;
		end else if (state_q == sfp_pkg::ST_SEL && !paused) begin
			// sample inputs on the rising edge
			if (rise && !txActive_q) begin
				if (quadOk) begin
					rxShift_d = {rxShift_q[3:0], lanes[3], lanes[2], lanes[1], lanes[0]};
				end else if (step == sfp_pkg::STEP_DUAL) begin
					rxShift_d = {rxShift_q[5:0], lanes[1], lanes[0]};
				end else begin
					rxShift_d = {rxShift_q[6:0], lanes[0]};
				end
				// a byte completes when the count wraps at eight bits
				if (cntSum == sfp_pkg::BITS_PER_BYTE) begin
					rxCnt_d   = 4'h0;
					rxByte_d  = rxShift_d;
					rxValid_d = 1'b1;
				end else begin
					rxCnt_d = cntSum;
				end
			end
			// outputs change on the falling edge
			if (fall && txActive_q) begin
				if (quadOk) begin
					laneOut_d = txShift_q[7:4];
					txShift_d = {txShift_q[3:0], 4'h0};
				end else if (step == sfp_pkg::STEP_DUAL) begin
					laneOut_d = {2'h0, txShift_q[7:6]};
					txShift_d = {txShift_q[5:0], 2'h0};
				end else begin
					laneOut_d = {2'h0, txShift_q[7], 1'b0};
					txShift_d = {txShift_q[6:0], 1'b0};
				end
			end
		end
		// a new byte from the decoder reloads the transmit path
		if (txLoad && state_q == sfp_pkg::ST_SEL) begin
			txShift_d  = txByte;
			txActive_d = 1'b1;
		end
		if (state_q == sfp_pkg::ST_SEL && !selN && txActive_q && !paused) begin
			laneOe_d = quadOk ? sfp_pkg::OE_QUAD :
				(step == sfp_pkg::STEP_DUAL) ? sfp_pkg::OE_DUAL : sfp_pkg::OE_SINGLE;
		end
		// protect pin with write disable blocks status writes
		// protect pin ignored under quad enable
		if (stWrReq && !hwRst) begin
			if (swd && !quadEnableBit && !lanes[2]) begin
				stWrRejected_d = 1'b1;
			end else begin
				statusBits_d = stWrData;
			end
		end
		// hardware reset floats and forgets the sequence
		if (hwRst) begin
			state_d    = sfp_pkg::ST_WAITFALL;
			rxCnt_d    = 4'h0;
			txActive_d = 1'b0;
			laneOe_d   = 4'h0;
		end
	end

	// registers; clock history resets to the sync level, so no false edge
	always_ff @(posedge mclk) begin
		if (rst) begin
			sclkPrev_q      <= sfp_pkg::PIN_RESET[sfp_pkg::PIN_SCLK];
			selPrev_q       <= 1'b1;
			state_q         <= sfp_pkg::ST_WAITFALL;
			rxShift_q       <= 8'h00;
			rxCnt_q         <= 4'h0;
			txShift_q       <= 8'h00;
			txActive_q      <= 1'b0;
			laneOut_q       <= 4'h0;
			laneOe_q        <= 4'h0;
			rxByte_q        <= 8'h00;
			rxValid_q       <= 1'b0;
			statusBits_q    <= sfp_pkg::STAT_RESET;
			stWrRejected_q  <= 1'b0;
			standby_q       <= 1'b1;
			pauseActive_q   <= 1'b0;
			hwResetActive_q <= 1'b0;
		end else begin
			sclkPrev_q      <= sclkPrev_d;
			selPrev_q       <= selPrev_d;
			state_q         <= state_d;
			rxShift_q       <= rxShift_d;
			rxCnt_q         <= rxCnt_d;
			txShift_q       <= txShift_d;
			txActive_q      <= txActive_d;
			laneOut_q       <= laneOut_d;
			laneOe_q        <= laneOe_d;
			rxByte_q        <= rxByte_d;
			rxValid_q       <= rxValid_d;
			statusBits_q    <= statusBits_d;
			stWrRejected_q  <= stWrRejected_d;
			standby_q       <= selN;
			pauseActive_q   <= paused;
			hwResetActive_q <= hwRst;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	deselect_float_a: assert property (selN |=> laneOe_q == 4'h0)
		else $error("lanes driven while deselected");
	standby_enter_a: assert property (selN |=> standby_q)
		else $error("standby not shown while deselected");
	arm_wait_a: assert property (state_q == sfp_pkg::ST_WAITFALL |=> !rxValid_q)
		else $error("byte accepted before select fell");
	rise_sample_a: assert property (rxValid_q |-> $past(rise) && !$past(paused))
		else $error("byte completed without a rising edge");
	fall_drive_a: assert property ($changed(laneOut_q) |-> $past(fall))
		else $error("lane output changed off a falling edge");
	quad_lanes_a: assert property (laneOe_q[3] |-> $past(quadEnableBit))
		else $error("lane 3 driven without quad enable");
	status_lock_a: assert property (stWrReq && swd && !quadEnableBit && !lanes[2] && !hwRst
		|=> stWrRejected_q && $stable(statusBits_q))
		else $error("protected status write not refused");
	quad_unlock_a: assert property (stWrReq && quadEnableBit && !hwRst
		|=> !stWrRejected_q && statusBits_q == $past(stWrData))
		else $error("status write refused under quad enable");
	quad_norole_a: assert property (quadEnableBit && (dedicatedVariant == 1'b0)
		|=> !pauseActive_q && !$past(hwRst))
		else $error("lane 3 role active under quad enable");
	role_reset_a: assert property (!quadEnableBit && !dedicatedVariant && pinRoleSelect
		&& !lanes[3] |=> hwResetActive_q)
		else $error("lane 3 reset role not honoured");
	dedicated_hold_a: assert property (dedicatedVariant && dedRstS && !lanes[3]
		|=> !hwResetActive_q)
		else $error("dedicated part reset from lane 3");
	dedicated_off_a: assert property (dedicatedVariant && dedResetDisable && lanes[3]
		|=> !hwResetActive_q)
		else $error("disabled dedicated reset still acted");
	pause_float_a: assert property ((paused && !hwRst) ##1 (paused && !hwRst)
		|=> laneOe_q == 4'h0 && $stable(rxCnt_q))
		else $error("pause did not freeze and float");
	reset_float_a: assert property (hwRst |=> laneOe_q == 4'h0
		&& state_q == sfp_pkg::ST_WAITFALL)
		else $error("hardware reset did not float or rearm");
	byte_seen_c: cover property (rxValid_q);
	drive_quad_c: cover property (laneOe_q == sfp_pkg::OE_QUAD);
	pause_mid_c: cover property (state_q == sfp_pkg::ST_SEL && paused);
	reject_c: cover property (stWrRejected_q);
endmodule

// >>> inc/sfp_pkg.sv
package sfp_pkg;
	// lane widths requested by the command decoder
	localparam logic [1:0] LANES_SINGLE = 2'h0;
	localparam logic [1:0] LANES_DUAL   = 2'h1;
	localparam logic [1:0] LANES_QUAD   = 2'h2;
	// status bit positions: protect bits low, then quad enable, then write disable
	localparam int STAT_PROT0_POS = 0;
	localparam int STAT_QUAD_POS  = 4;
	localparam int STAT_SWD_POS = 5;
	localparam int STAT_WIDTH   = 6;
	localparam logic [5:0] STAT_RESET = 6'h00;
	// pin synchroniser slots
	localparam int PIN_SEL   = 0;
	localparam int PIN_SCLK  = 1;
	localparam int PIN_LANE0 = 2;
	localparam int PIN_DRST  = 6;
	localparam int PIN_COUNT = 7;
	localparam logic [6:0] PIN_RESET = 7'h7f;
	// bit counting within one byte
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] STEP_SINGLE   = 4'h1;
	localparam logic [3:0] STEP_DUAL     = 4'h2;
	localparam logic [3:0] STEP_QUAD     = 4'h4;
	// lane output enable patterns
	localparam logic [3:0] OE_SINGLE = 4'h2;
	localparam logic [3:0] OE_DUAL   = 4'h3;
	localparam logic [3:0] OE_QUAD   = 4'hf;
	// link sequencing states
	typedef enum logic [2:0] {
		ST_WAITFALL = 3'b001,
		ST_DESEL    = 3'b010,
		ST_SEL      = 3'b100
	} sfp_state_t;
endpackage

// >>> hdl/sfp_sync.sv
`timescale 1ns/1ps
// two-stage synchroniser, one pair of flops per pin
module sfp_sync (
	// clock and reset
	input  wire logic                         mclk,
	input  wire logic                         rst,
	// asynchronous pins and their safe copies
	input  wire logic [sfp_pkg::PIN_COUNT-1:0] pinAsync,
	output logic      [sfp_pkg::PIN_COUNT-1:0] pinSync
);
	// first stage is read only by the second stage
	logic [sfp_pkg::PIN_COUNT-1:0] meta_q;

	genvar i;
	generate
		for (i = 0; i < sfp_pkg::PIN_COUNT; i++) begin : g_bit
			// reset to idle-high so select and pause look inactive
			always_ff @(posedge mclk) begin
				if (rst) begin
					meta_q[i]  <= sfp_pkg::PIN_RESET[i];
					pinSync[i] <= sfp_pkg::PIN_RESET[i];
				end else begin
					meta_q[i]  <= pinAsync[i];
					pinSync[i] <= meta_q[i];
				end
			end
		end
	endgenerate
endmodule

// >>> dv/sfp_host.sv
`timescale 1ns/1ps
// host controller model: select, clock and lane drive
module sfp_host (
	// block clock; pin edges are placed off its sampling edge
	input  wire logic       mclk,
	// wire levels seen on the lanes
	input  wire logic [3:0] laneW,
	// pins toward the device
	output logic            selectN,
	output logic            sclk,
	output logic [3:0]      hostDrv,
	output logic [3:0]      hostOe
);
	// idle: deselected, clock low, lanes released
	initial begin
		selectN = 1'b1;
		sclk = 1'b0;
		hostDrv = 4'hf;
		hostOe = 4'h0;
	end
	// clock parked at idle level before select moves
	task automatic frame(input logic on, input logic cpol);
		@(negedge mclk);
		sclk = cpol;
		hostOe = 4'h0;
		#24 selectN = ~on;
		#48;
	endtask
	// data set with clock low, sampled at the rise
	task automatic steps(input logic [7:0] d, input int n, input int w, input logic drv,
			output logic [7:0] r);
		logic [3:0] m;
		m = 4'((1 << w) - 1);
		r = 8'h00;
		@(negedge mclk);
		for (int i = 0; i < n; i++) begin
			sclk = 1'b0;
			hostOe = drv ? (hostOe | m) : (hostOe & ~m);
			hostDrv = (hostDrv & ~m) | 4'(d >> (8 - w));
			d = d << w;
			#24 sclk = 1'b1;
			r = (w == 1) ? {r[6:0], laneW[1]} : 8'((r << w) | (laneW & m));
			#24;
		end
	endtask
	// lane 2 or 3 pulled low on command only, never mid write
	task automatic pin(input int i, input logic low);
		hostOe[i] = low;
		hostDrv[i] = ~low;
	endtask
endmodule

// >>> dv/sfp_pin_if_tb.sv
`timescale 1ns/1ps
// self-checking bench for the pin interface
module sfp_pin_if_tb;
	// clock, reset and lanes
	logic       mclk, rst, selectN, sclk, dedResetN;
	logic       junk = 1'b0;
	logic [3:0] laneW, laneOut, laneOe, hostDrv, hostOe;
	// configuration levels
	logic       dedicatedVariant, pinRoleSelect, dedResetDisable;
	logic [1:0] laneMode;
	// decoder side
	logic [7:0] rxByte, txByte, r;
	logic       rxValid, txLoad, stWrReq, stWrRejected;
	logic [5:0] stWrData, statusBits;
	logic       standby, pauseActive, hwResetActive;
	// tallies
	int         errTotal, checkCount, rxCount, rejCount;

	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	// released lanes: pull-up on 2 and 3, a moving pattern on 0 and 1
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			laneW[i] = laneOe[i] ? laneOut[i] : hostOe[i] ? hostDrv[i] : (i > 1 ? 1'b1 : junk);
		end
	end
	// pulse counters, so a one-cycle pulse is never missed
	always @(posedge mclk) begin
		junk <= ~junk;
		rxCount <= rxCount + int'(rxValid);
		rejCount <= rejCount + int'(stWrRejected);
	end

	sfp_pin_if uut (.mclk(mclk), .rst(rst), .selectN(selectN), .sclk(sclk), .laneIn(laneW),
		.laneOut_q(laneOut), .laneOe_q(laneOe), .dedResetN(dedResetN),
		.dedicatedVariant(dedicatedVariant), .pinRoleSelect(pinRoleSelect),
		.dedResetDisable(dedResetDisable), .laneMode(laneMode), .rxByte_q(rxByte),
		.rxValid_q(rxValid), .txLoad(txLoad), .txByte(txByte), .stWrReq(stWrReq),
		.stWrData(stWrData), .statusBits_q(statusBits), .stWrRejected_q(stWrRejected),
		.standby_q(standby), .pauseActive_q(pauseActive), .hwResetActive_q(hwResetActive));
	sfp_host host (.mclk(mclk), .laneW(laneW), .selectN(selectN), .sclk(sclk), .hostDrv(hostDrv),
		.hostOe(hostOe));

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask
	// one comparison, counted
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checkCount++;
		if (seen !== exp) begin
			errTotal++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// status write pulse, answer one cycle later
	task automatic stWrite(input logic [5:0] d);
		// a protect pin moved just before needs both sync stages
		cyc(3);
		@(posedge mclk) begin
			stWrReq <= 1'b1;
			stWrData <= d;
		end
		@(posedge mclk) stWrReq <= 1'b0;
		cyc(2);
	endtask
	// byte handed to the shifter
	task automatic load(input logic [7:0] b);
		@(posedge mclk) begin
			txLoad <= 1'b1;
			txByte <= b;
		end
		@(posedge mclk) txLoad <= 1'b0;
		cyc(3);
	endtask
	task automatic finishTest();
		$display("checks %0d errors %0d", checkCount, errTotal);
		if (errTotal == 0 && checkCount > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	initial begin
		rst = 1'b1;
		{txLoad, txByte, stWrReq, stWrData} = 16'h0000;
		{dedResetN, dedicatedVariant, pinRoleSelect, dedResetDisable} = 4'h8;
		laneMode = sfp_pkg::LANES_SINGLE;
		cyc(16);
		rst <= 1'b0;
		cyc(3);
		check("standby", standby, 1);
		check("status", statusBits, 0);
		host.steps(8'hff, 8, 1, 1, r);
		cyc(6);
		check("rx deselected", 8'(rxCount), 0);
		host.frame(1, 0);
		host.steps(8'ha5, 8, 1, 1, r);
		cyc(6);
		check("rx single", rxByte, 8'ha5);
		check("standby sel", standby, 0);
		host.frame(0, 0);
		// single read in clock mode 3
		host.frame(1, 1);
		load(8'h6b);
		host.steps(8'h00, 8, 1, 0, r);
		check("tx single", r, 8'h6b);
		check("oe single", 8'(laneOe), 8'(sfp_pkg::OE_SINGLE));
		host.frame(0, 1);
		cyc(4);
		check("oe desel", 8'(laneOe), 0);
		// dual receive
		@(posedge mclk) laneMode <= sfp_pkg::LANES_DUAL;
		host.frame(1, 0);
		host.steps(8'h3c, 4, 2, 1, r);
		cyc(6);
		check("rx dual", rxByte, 8'h3c);
		host.frame(0, 0);
		@(posedge mclk) laneMode <= sfp_pkg::LANES_SINGLE;
		// pause in mid byte, bits clocked meanwhile are lost
		host.frame(1, 0);
		host.steps(8'h9f, 4, 1, 1, r);
		host.pin(3, 1);
		cyc(5);
		check("pause", pauseActive, 1);
		host.steps(8'h00, 2, 1, 1, r);
		host.pin(3, 0);
		cyc(5);
		host.steps(8'hf0, 4, 1, 1, r);
		cyc(6);
		check("rx paused", rxByte, 8'h9f);
		check("rx count", 8'(rxCount), 3);
		host.frame(0, 0);
		// lane 3 as reset: partial byte dropped, fresh select needed
		@(posedge mclk) pinRoleSelect <= 1'b1;
		host.frame(1, 0);
		host.steps(8'hc3, 4, 1, 1, r);
		host.pin(3, 1);
		cyc(5);
		check("hw reset", hwResetActive, 1);
		stWrite(6'h0f);
		check("status in reset", statusBits, 0);
		host.pin(3, 0);
		host.steps(8'hc3, 8, 1, 1, r);
		cyc(6);
		check("rx after reset", 8'(rxCount), 3);
		host.frame(0, 0);
		// dedicated part: lane 3 pauses, own pin resets unless disabled
		@(posedge mclk) dedicatedVariant <= 1'b1;
		host.frame(1, 0);
		host.pin(3, 1);
		cyc(5);
		check("ded pause", {pauseActive, hwResetActive}, 2);
		host.pin(3, 0);
		@(posedge mclk) dedResetN <= 1'b0;
		cyc(5);
		check("ded reset", hwResetActive, 1);
		@(posedge mclk) dedResetDisable <= 1'b1;
		cyc(5);
		check("ded disabled", hwResetActive, 0);
		host.frame(0, 0);
		@(posedge mclk) {dedResetN, dedicatedVariant} <= 2'h2;
		// protect pin against the write disable bit
		host.pin(2, 1);
		stWrite(6'h20);
		check("swd clear", statusBits, 8'h20);
		stWrite(6'h2f);
		check("swd set", {rejCount[1:0], statusBits}, 8'h60);
		host.pin(2, 0);
		stWrite(6'h30);
		host.pin(2, 1);
		stWrite(6'h31);
		check("quad protect", statusBits, 8'h31);
		host.pin(2, 0);
		// quad enable: lane 3 low does nothing for either role
		host.frame(1, 0);
		for (int k = 0; k < 2; k++) begin
			@(posedge mclk) pinRoleSelect <= k[0];
			host.pin(3, 1);
			cyc(5);
			check("quad lane 3", {pauseActive, hwResetActive}, 0);
			host.pin(3, 0);
		end
		host.frame(0, 0);
		@(posedge mclk) laneMode <= sfp_pkg::LANES_QUAD;
		host.frame(1, 0);
		host.steps(8'h5a, 2, 4, 1, r);
		cyc(6);
		check("rx quad", rxByte, 8'h5a);
		host.frame(0, 0);
		host.frame(1, 1);
		load(8'hc6);
		host.steps(8'h00, 2, 4, 0, r);
		check("tx quad", r, 8'hc6);
		check("oe quad", 8'(laneOe), 8'(sfp_pkg::OE_QUAD));
		host.frame(0, 1);
		// dual transmit in clock mode 3, bit 7 on lane 1
		@(posedge mclk) laneMode <= sfp_pkg::LANES_DUAL;
		host.frame(1, 1);
		load(8'h93);
		host.steps(8'h00, 4, 2, 0, r);
		check("tx dual", r, 8'h93);
		check("oe dual", 8'(laneOe), 8'(sfp_pkg::OE_DUAL));
		host.frame(0, 1);
		finishTest();
	end
endmodule
